// *** core/scs_latch_flag.sv ***
// one latched status flag with write-one unlatch and rising-edge request
// assumes set, unlatch and release are on the core clock
`timescale 1ns/10ps
module scs_latch_flag (
  input  wire logic core_clk_in,
  input  wire logic reset_n_in,
  input  wire logic set_in,
  input  wire logic unlatch_in,
  input  wire logic release_in,
  input  wire logic arm_in,
  output logic      flag_out,
  output logic      request_out
);
  logic flag_q;
  logic flag_d;
  logic pend_q;
  logic pend_d;
  wire  clear_ok = (unlatch_in | pend_q) & release_in;

  // set wins over a clear in the same cycle; an unlatch waits for release
  assign flag_d      = set_in | (flag_q & ~clear_ok);
  assign pend_d      = flag_q & ~clear_ok & ~set_in & (pend_q | unlatch_in);
  assign request_out = set_in & ~flag_q & arm_in;
  assign flag_out    = flag_q;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      flag_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      pend_q <= pend_d;
    end
  end
endmodule // scs_latch_flag

// *** core/scs_status_flags.sv ***
// transmit and receive command/status flag logic for one serial channel
// assumes transmitter, receiver and queues run on core_clk_in; the serial clock,
// data and carrier pins arrive asynchronously and are synchronised here
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
module scs_status_flags (
  input  wire logic              core_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [2:0]        reg_addr_in,
  input  wire logic [15:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [15:0]       reg_rdata_out,
  input  wire logic              dma_rx_read_in,
  input  wire logic              receive_clock_in,
  input  wire logic              rxd_in,
  input  wire logic              carrier_detect_n_in,
  input  wire logic              transmit_clock_in,
  input  wire scs_pkg::scs_txev_t tx_event_in,
  input  wire logic              tx_idling_in,
  input  wire logic              tx_shifting_in,
  input  wire logic              tx_need_char_in,
  input  wire logic [3:0]        tx_bits_left_in,
  input  wire logic [5:0]        tx_queue_level_in,
  input  wire logic              rx_enable_pulse_in,
  input  wire logic              rx_sync_found_in,
  input  wire logic              rx_flag_found_in,
  input  wire logic              rx_addr_match_in,
  input  wire logic              rx_preamble_start_in,
  input  wire logic              rx_push_in,
  input  wire scs_pkg::scs_rxst_t rx_push_raw_in,
  input  wire logic              rx_hdlc_short_in,
  input  wire logic              rx_cv_command_in,
  input  wire scs_pkg::scs_rxst_t rx_oldest_in,
  input  wire scs_pkg::scs_rxst_t rx_second_in,
  input  wire logic [5:0]        rx_queue_level_in,
  input  wire logic [15:0]       rx_data_in,
  output logic                   rx_push_out,
  output scs_pkg::scs_rxst_t     rx_push_status_out,
  output logic                   receive_data_read_out,
  output logic                   tx_int_request_out,
  output logic                   rx_int_request_out
);
  // pin synchronisation
  logic [3:0] pins_s;
  logic       rclk_s;
  logic       rxd_s;
  logic       dcd_n_s;
  logic       tclk_s;
  logic       rclk_prev_q;
  logic       tclk_prev_q;
  logic       dcd_n_prev_q;

  scs_sync2 #(.W(4)) u_sync (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .d_in        ({receive_clock_in, rxd_in, carrier_detect_n_in, transmit_clock_in}),
    .q_out       (pins_s)
  );

  assign rclk_s  = pins_s[3];
  assign rxd_s   = pins_s[2];
  assign dcd_n_s = pins_s[1];
  assign tclk_s  = pins_s[0];

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rclk_prev_q  <= 1'b0;
      tclk_prev_q  <= 1'b0;
      // matches the synchroniser's reset level, so no false fall follows reset
      dcd_n_prev_q <= 1'b0;
    end else begin
      rclk_prev_q  <= rclk_s;
      tclk_prev_q  <= tclk_s;
      dcd_n_prev_q <= dcd_n_s;
    end
  end

  wire rclk_rise = rclk_s & ~rclk_prev_q;
  wire tclk_rise = tclk_s & ~tclk_prev_q;
  wire dcd_fall  = dcd_n_prev_q & ~dcd_n_s;

  // register bank
  logic [15:0] tx_int_ctl_q;
  logic [15:0] rx_int_ctl_q;
  logic [15:0] chan_mode_q;
  logic [2:0]  idle_sel_q;
  logic [15:0] rdata_q;

  wire wr_tx_status = reg_wr_in & (reg_addr_in == scs_pkg::OFS_TX_STATUS);
  wire wr_rx_status = reg_wr_in & (reg_addr_in == scs_pkg::OFS_RX_STATUS);
  wire wr_tx_ictl   = reg_wr_in & (reg_addr_in == scs_pkg::OFS_TX_INT_CTL);
  wire wr_rx_ictl   = reg_wr_in & (reg_addr_in == scs_pkg::OFS_RX_INT_CTL);
  wire wr_mode      = reg_wr_in & (reg_addr_in == scs_pkg::OFS_CHAN_MODE);
  wire rd_rx_data   = reg_rd_in & (reg_addr_in == scs_pkg::OFS_RX_DATA);
  wire rx_data_read = rd_rx_data | dma_rx_read_in;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      tx_int_ctl_q <= scs_pkg::REG_RESET;
      rx_int_ctl_q <= scs_pkg::REG_RESET;
      chan_mode_q  <= scs_pkg::REG_RESET;
      idle_sel_q   <= 3'h0;
    end else begin
      if (wr_tx_ictl) tx_int_ctl_q <= reg_wdata_in;
      if (wr_rx_ictl) rx_int_ctl_q <= reg_wdata_in;
      if (wr_mode) chan_mode_q <= reg_wdata_in;
      if (wr_tx_status) idle_sel_q <= reg_wdata_in[scs_pkg::TX_IDLESEL_LSB +: 3];
    end
  end

  // mode decode
  wire [3:0] mode      = chan_mode_q[scs_pkg::MODE_LSB +: 4];
  wire [3:0] submode   = chan_mode_q[scs_pkg::SUBMODE_LSB +: 4];
  wire       addr_chk  = chan_mode_q[scs_pkg::ADDR_CHECK_BIT];
  wire       is_hdlc   = (mode == scs_pkg::MODE_HDLC) | (mode == scs_pkg::MODE_HDLC_LOOP);
  wire       is_cv     = (mode == scs_pkg::MODE_CV_ASYNC);
  wire       is_async  = (mode == scs_pkg::MODE_ASYNC) | is_cv;
  wire       is_sync   = ~is_async;
  wire       word_stat = rx_int_ctl_q[scs_pkg::RX_WORD_STATUS];

  // transmit events
  logic       idle_seen_q;
  logic [7:0] tx_set;
  logic [7:0] tx_flags;
  logic [7:0] tx_req;
  wire        idle_recurs = (idle_sel_q == scs_pkg::IDLE_SEL_SYNC) |
                            (idle_sel_q == scs_pkg::IDLE_SEL_FLAG);
  wire        tx_q_empty  = (tx_queue_level_in == 6'h00);
  // raised while bits remain so software sees it before the line goes dead
  wire        under_hit   = tclk_rise & tx_need_char_in & tx_q_empty &
                            (tx_bits_left_in == scs_pkg::UNDERRUN_LEAD);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      idle_seen_q <= 1'b0;
    end else if (!tx_idling_in) begin
      idle_seen_q <= 1'b0;
    end else if (tx_event_in.idle_first_bit) begin
      idle_seen_q <= 1'b1;
    end
  end

  always_comb begin
    tx_set                        = 8'h00;
    tx_set[scs_pkg::TX_PREAMBLE]  = is_sync & tx_event_in.preamble_end;
    tx_set[scs_pkg::TX_IDLE]      = idle_recurs ? tx_event_in.idle_unit_done :
                                    (tx_event_in.idle_first_bit & ~idle_seen_q);
    tx_set[scs_pkg::TX_ABORT]     = is_hdlc & tx_event_in.abort_end;
    tx_set[scs_pkg::TX_EOF]       = is_sync & tx_event_in.closing_end;
    tx_set[scs_pkg::TX_CRC]       = is_sync & tx_event_in.crc_end;
    tx_set[scs_pkg::TX_UNDER]     = under_hit;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_tx
      if (scs_pkg::TX_LATCH_MASK[gi]) begin : g_latch
        scs_latch_flag u_flag (
          .core_clk_in (core_clk_in),
          .reset_n_in  (reset_n_in),
          .set_in      (tx_set[gi]),
          .unlatch_in  (wr_tx_status & reg_wdata_in[gi]),
          .release_in  (1'b1),
          .arm_in      (tx_int_ctl_q[gi]),
          .flag_out    (tx_flags[gi]),
          .request_out (tx_req[gi])
        );
      end else begin : g_none
        assign tx_flags[gi] = 1'b0;
        assign tx_req[gi]   = 1'b0;
      end
    end
  endgenerate

  wire all_shifted = ~(is_async & tx_shifting_in);
  wire [15:0] tx_status_word = {5'h00, idle_sel_q,
                                tx_flags[7:3], all_shifted, tx_flags[1], tx_q_empty};

  // receive idle counter on synchronised serial clock
  logic [4:0] ones_q;
  wire  [4:0] ones_thr = is_hdlc ? scs_pkg::IDLE_ONES_HDLC : scs_pkg::IDLE_ONES_OTHER;
  wire        idle_hit = rclk_rise & rxd_s & (ones_q == ones_thr - 5'h01);

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      ones_q <= 5'h00;
    end else if (rclk_rise) begin
      if (!rxd_s) ones_q <= 5'h00;
      else if (ones_q != ones_thr) ones_q <= ones_q + 5'h01;
    end
  end

  // hunt exit per mode
  logic hunt_set;
  always_comb begin
    unique case (mode)
      scs_pkg::MODE_ASYNC,
      scs_pkg::MODE_CV_ASYNC:  hunt_set = rx_enable_pulse_in;
      scs_pkg::MODE_EXT_SYNC:  hunt_set = dcd_fall;
      scs_pkg::MODE_MONOSYNC,
      scs_pkg::MODE_BISYNC,
      scs_pkg::MODE_TBISYNC:   hunt_set = rx_sync_found_in;
      scs_pkg::MODE_HDLC,
      scs_pkg::MODE_HDLC_LOOP: hunt_set = rx_flag_found_in;
      scs_pkg::MODE_ETHERNET:  hunt_set = addr_chk ? rx_addr_match_in : rx_preamble_start_in;
      default:                 hunt_set = 1'b0;
    endcase
  end

  logic hunt_flag;
  logic hunt_req;
  logic idle_flag;
  logic idle_req;

  scs_latch_flag u_hunt (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .set_in      (hunt_set),
    .unlatch_in  (wr_rx_status & reg_wdata_in[scs_pkg::RX_HUNT]),
    .release_in  (1'b1),
    .arm_in      (rx_int_ctl_q[scs_pkg::RX_HUNT]),
    .flag_out    (hunt_flag),
    .request_out (hunt_req)
  );

  // the idle flag holds until the line has dropped back to zero
  scs_latch_flag u_idle (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .set_in      (idle_hit),
    .unlatch_in  (wr_rx_status & reg_wdata_in[scs_pkg::RX_IDLE]),
    .release_in  (~rxd_s),
    .arm_in      (rx_int_ctl_q[scs_pkg::RX_IDLE]),
    .flag_out    (idle_flag),
    .request_out (idle_req)
  );

  // per-character status queued with each received character
  scs_pkg::scs_rxst_t push_q;
  logic               push_v_q;
  scs_pkg::scs_rxst_t push_d;
  wire hdlc_short = is_hdlc & (submode != 4'h0) & rx_hdlc_short_in;
  wire cv_type    = is_cv & rx_cv_command_in;

  always_comb begin
    push_d             = rx_push_raw_in;
    push_d.short_frame = rx_push_raw_in.boundary & (hdlc_short | cv_type);
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      push_q   <= '0;
      push_v_q <= 1'b0;
    end else begin
      push_q   <= push_d;
      push_v_q <= rx_push_in;
    end
  end

  // byte exceptions, captured on each receive-data read
  logic first_exc_q;
  logic second_exc_q;
  wire  two_queued = (rx_queue_level_in > 6'h01);
  wire  old_exc    = rx_oldest_in.boundary | rx_oldest_in.parity | rx_oldest_in.overrun;
  wire  sec_exc    = rx_second_in.boundary | rx_second_in.parity | rx_second_in.overrun;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      first_exc_q  <= 1'b0;
      second_exc_q <= 1'b0;
    end else if (rx_data_read) begin
      first_exc_q  <= old_exc;
      // with one character left the value is undefined; zero is given
      second_exc_q <= two_queued & sec_exc;
    end
  end

  scs_pkg::scs_rxst_t view;
  assign view = (word_stat & two_queued) ? (rx_oldest_in | rx_second_in) : rx_oldest_in;

  wire [15:0] rx_status_word = {second_exc_q, first_exc_q, 5'h00, view.short_frame,
                                hunt_flag, idle_flag, 1'b0, view.boundary,
                                view.crc_frame, view.parity, view.overrun,
                                (rx_queue_level_in != 6'h00)};

  // read mux; data appears only in the cycle after the strobe
  logic [15:0] rdata_mux;
  always_comb begin
    unique case (reg_addr_in)
      scs_pkg::OFS_TX_STATUS:  rdata_mux = tx_status_word;
      scs_pkg::OFS_RX_STATUS:  rdata_mux = rx_status_word;
      scs_pkg::OFS_TX_INT_CTL: rdata_mux = tx_int_ctl_q;
      scs_pkg::OFS_RX_INT_CTL: rdata_mux = rx_int_ctl_q;
      scs_pkg::OFS_CHAN_MODE:  rdata_mux = chan_mode_q;
      scs_pkg::OFS_RX_DATA:    rdata_mux = rx_data_in;
      default:                 rdata_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) rdata_q <= 16'h0000;
    else rdata_q <= reg_rd_in ? rdata_mux : 16'h0000;
  end

  assign reg_rdata_out         = rdata_q;
  assign rx_push_out           = push_v_q;
  assign rx_push_status_out    = push_q;
  assign receive_data_read_out = rx_data_read;
  assign tx_int_request_out    = |tx_req;
  assign rx_int_request_out    = hunt_req | idle_req;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_preamble_set: assert property (
    is_sync && tx_event_in.preamble_end |=> tx_flags[scs_pkg::TX_PREAMBLE])
    else $error("preamble flag not set");

  chk_tx_flag_hold: assert property (
    tx_flags[scs_pkg::TX_CRC] && !(wr_tx_status && reg_wdata_in[scs_pkg::TX_CRC])
    |=> tx_flags[scs_pkg::TX_CRC])
    else $error("tx flag dropped without write one");

  chk_tx_request: assert property (
    $rose(tx_flags[scs_pkg::TX_EOF]) && $past(tx_int_ctl_q[scs_pkg::TX_EOF])
    |-> $past(tx_int_request_out))
    else $error("armed tx flag rose without request");

  chk_empty_bit: assert property (
    reg_rd_in && (reg_addr_in == scs_pkg::OFS_TX_STATUS)
    |=> reg_rdata_out[scs_pkg::TX_EMPTY] == $past(tx_queue_level_in == 6'h00))
    else $error("queue empty bit wrong");

  chk_underrun_set: assert property (
    under_hit |=> tx_flags[scs_pkg::TX_UNDER])
    else $error("underrun not raised");

  chk_idle_count: assert property (
    rclk_rise && rxd_s && ones_q == ones_thr - 5'h01 |=> idle_flag)
    else $error("idle received not set");

  chk_idle_hold: assert property (
    idle_flag && rxd_s |=> idle_flag)
    else $error("idle flag cleared while line high");

  chk_first_exc: assert property (
    rx_data_read |=> first_exc_q == $past(old_exc))
    else $error("first byte exception wrong");

  chk_second_exc: assert property (
    rx_data_read && two_queued |=> second_exc_q == $past(sec_exc))
    else $error("second byte exception wrong");

  chk_reset_clear: assert property (
    $rose(reset_n_in) |-> (tx_flags == 8'h00) && !hunt_flag && !idle_flag && !first_exc_q)
    else $error("flags not clear after reset");
endmodule // scs_status_flags

// *** core/scs_sync2.sv ***
// two-stage synchroniser for pins from outside the core clock domain
// assumes the first stage feeds only the second
`timescale 1ns/10ps
module scs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule // scs_sync2

// *** include/scs_pkg.sv ***
// constants, field positions and carrier types for the serial channel status flags
// assumes one core clock domain; pins are synchronised inside the block
package scs_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 16;
  localparam int          LEVEL_W         = 6;
  localparam logic [2:0]  OFS_TX_STATUS   = 3'h0;
  localparam logic [2:0]  OFS_RX_STATUS   = 3'h1;
  localparam logic [2:0]  OFS_TX_INT_CTL  = 3'h2;
  localparam logic [2:0]  OFS_RX_INT_CTL  = 3'h3;
  localparam logic [2:0]  OFS_CHAN_MODE   = 3'h4;
  localparam logic [2:0]  OFS_RX_DATA     = 3'h5;
  // transmit status bit positions
  localparam int          TX_PREAMBLE     = 7;
  localparam int          TX_IDLE         = 6;
  localparam int          TX_ABORT        = 5;
  localparam int          TX_EOF          = 4;
  localparam int          TX_CRC          = 3;
  localparam int          TX_ALL_SHIFTED_OUT      = 2;
  localparam int          TX_UNDER        = 1;
  localparam int          TX_EMPTY        = 0;
  localparam logic [7:0]  TX_LATCH_MASK   = 8'hFA;
  localparam int          TX_IDLESEL_LSB  = 8;
  localparam int          TX_IDLESEL_W    = 3;
  // receive status and receive interrupt control bit positions
  localparam int          RX_SECOND_EXC   = 15;
  localparam int          RX_FIRST_EXC    = 14;
  localparam int          RX_SHORT        = 8;
  localparam int          RX_HUNT         = 7;
  localparam int          RX_IDLE         = 6;
  localparam int          RX_AVAIL        = 0;
  localparam int          RX_WORD_STATUS  = 3;
  // channel mode fields
  localparam int          MODE_LSB        = 0;
  localparam int          SUBMODE_LSB     = 4;
  localparam int          ADDR_CHECK_BIT  = 8;
  localparam logic [3:0]  MODE_ASYNC      = 4'h0;
  localparam logic [3:0]  MODE_EXT_SYNC   = 4'h1;
  localparam logic [3:0]  MODE_MONOSYNC   = 4'h2;
  localparam logic [3:0]  MODE_BISYNC     = 4'h3;
  localparam logic [3:0]  MODE_TBISYNC    = 4'h4;
  localparam logic [3:0]  MODE_HDLC       = 4'h5;
  localparam logic [3:0]  MODE_HDLC_LOOP  = 4'h6;
  localparam logic [3:0]  MODE_ETHERNET   = 4'h7;
  localparam logic [3:0]  MODE_CV_ASYNC   = 4'h8;
  localparam logic [2:0]  IDLE_SEL_SYNC   = 3'h1;
  localparam logic [2:0]  IDLE_SEL_FLAG   = 3'h2;
  localparam logic [4:0]  IDLE_ONES_HDLC  = 5'h0F;
  localparam logic [4:0]  IDLE_ONES_OTHER = 5'h10;
  localparam logic [3:0]  UNDERRUN_LEAD   = 4'h2;
  localparam logic [15:0] REG_RESET       = 16'h0000;

  typedef struct packed {
    logic preamble_end;
    logic idle_first_bit;
    logic idle_unit_done;
    logic abort_end;
    logic closing_end;
    logic crc_end;
  } scs_txev_t;

  typedef struct packed {
    logic short_frame;
    logic boundary;
    logic crc_frame;
    logic parity;
    logic overrun;
  } scs_rxst_t;
endpackage

// *** tb/scs_line_model.sv ***
// far-side line model: bursts of the serial clock shared by transmitter and receiver
// assumes the bench asks for a new burst only after the previous one has ended
`timescale 1ns/10ps
module scs_line_model (
  input  wire logic       go_in,
  input  wire logic [4:0] edges_in,
  output logic            line_clk_out
);
  // the far side clocks only within frames, so the line rests low between bursts
  initial begin
    line_clk_out = 1'b0;
    forever begin
      @(posedge go_in);
      repeat (edges_in) begin
        #80 line_clk_out = 1'b1;
        #80 line_clk_out = 1'b0;
      end
    end
  end
endmodule // scs_line_model

// *** tb/tb.sv ***
// self-checking bench for the serial channel status flags
// assumes one core clock; the line model supplies serial clock bursts
`timescale 1ns/10ps
module tb;
  logic               core_clk, reset_n, reg_wr, reg_rd, go, rxd, need_char, shifting;
  logic               line_clk, tx_req, rx_req, dma_rd, idling, push, hshort, cvcmd, pushv, pop;
  logic [2:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata, rx_data, got, arm;
  logic [11:0]        ev;
  logic [3:0]         bits_left;
  logic [4:0]         edges;
  logic [5:0]         tx_level, rx_level;
  scs_pkg::scs_rxst_t oldest, second, w, raw, pushed;
  int                 err_total, checks_done, cycles, tx_reqs, rx_reqs, n, pops;
  localparam logic [15:0] HM [8] = '{16'h0000, 16'h0002, 16'h0003, 16'h0004,
                                     16'h0005, 16'h0107, 16'h0007, 16'h0001};
  localparam int          HB [8] = '{6, 7, 7, 7, 8, 9, 10, 11};
  localparam int          FB [5] = '{7, 6, 5, 4, 3};
  localparam int          EB [5] = '{5, 3, 2, 1, 0};
  localparam logic [15:0] PM [3] = '{16'h0008, 16'h0015, 16'h0005};

  scs_line_model scs_line_model_inst (.go_in(go), .edges_in(edges), .line_clk_out(line_clk));
  scs_status_flags scs_status_flags_inst (
    .core_clk_in(core_clk), .reset_n_in(reset_n), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .dma_rx_read_in(dma_rd), .receive_clock_in(line_clk),
    .rxd_in(rxd), .carrier_detect_n_in(~ev[11]), .transmit_clock_in(line_clk),
    .tx_event_in(ev[5:0]), .tx_idling_in(idling), .tx_shifting_in(shifting),
    .tx_need_char_in(need_char), .tx_bits_left_in(bits_left), .tx_queue_level_in(tx_level),
    .rx_enable_pulse_in(ev[6]), .rx_sync_found_in(ev[7]), .rx_flag_found_in(ev[8]),
    .rx_addr_match_in(ev[9]), .rx_preamble_start_in(ev[10]), .rx_push_in(push),
    .rx_push_raw_in(raw), .rx_hdlc_short_in(hshort), .rx_cv_command_in(cvcmd),
    .rx_oldest_in(oldest), .rx_second_in(second), .rx_queue_level_in(rx_level),
    .rx_data_in(rx_data), .rx_push_out(pushv), .rx_push_status_out(pushed),
    .receive_data_read_out(pop), .tx_int_request_out(tx_req), .rx_int_request_out(rx_req));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // request pulses are counted so a missing or a doubled request both show
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (tx_req === 1'b1) tx_reqs <= tx_reqs + 1;
    if (rx_req === 1'b1) rx_reqs <= rx_reqs + 1;
    if (pop === 1'b1) pops <= pops + 1;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic [2:0] a, input int b, input logic e);
    rd(a);
    chk(16'(got[b]), 16'(e));
  endtask

  task automatic fire(input int b);
    @(posedge core_clk);
    ev[b] <= 1'b1;
    @(posedge core_clk);
    ev[b] <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // eight core cycles per serial period, plus synchroniser slack
  task automatic burst(input int k);
    @(posedge core_clk);
    edges <= 5'(k);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (8 * k + 6) @(posedge core_clk);
  endtask

  function automatic logic exc(input scs_pkg::scs_rxst_t s);
    return s.boundary | s.parity | s.overrun;
  endfunction

  // queued short-frame bit: hdlc with address processing, or violation type
  function automatic logic sf(input logic [15:0] m, input scs_pkg::scs_rxst_t r,
                              input logic h, input logic c);
    return r.boundary & ((((m[3:0] == 4'h5) | (m[3:0] == 4'h6)) & (m[7:4] != 4'h0) & h) |
                         ((m[3:0] == 4'h8) & c));
  endfunction

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    {reset_n, reg_wr, reg_rd, go, rxd, need_char, shifting, dma_rd} = '0;
    {idling, push, hshort, cvcmd} = '0;
    raw = '0;
    {reg_addr, reg_wdata, ev, edges, bits_left, tx_level, rx_level, rx_data} = '0;
    oldest = '0;
    second = '0;
    void'($urandom(14735));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      rd(3'(a));
      chk(got, (a == 0) ? 16'h0005 : 16'h0000);
    end
    $display("test reset done");
    wr(3'h4, 16'h0005);
    arm = (16'($urandom) & 16'h00FA) | 16'h0010;
    wr(3'h2, arm);
    wr(3'h0, 16'h0100);
    for (int i = 0; i < 5; i++) begin
      n = tx_reqs;
      fire(EB[i]);
      chk(16'(tx_reqs - n), 16'(arm[FB[i]]));
      chkb(3'h0, FB[i], 1'b1);
      wr(3'h0, 16'h0100);
      fire(EB[i]);
      chkb(3'h0, FB[i], 1'b1);
      chk(16'(tx_reqs - n), 16'(arm[FB[i]]));
      wr(3'h0, 16'h0100 | (16'h0001 << FB[i]));
      chkb(3'h0, FB[i], 1'b0);
    end
    $display("test transmit flags done");
    wr(3'h0, 16'h0000);
    idling <= 1'b1;
    fire(4);
    chkb(3'h0, 6, 1'b1);
    wr(3'h0, 16'h0040);
    fire(4);
    chkb(3'h0, 6, 1'b0);
    @(posedge core_clk);
    idling <= 1'b0;
    need_char <= 1'b1;
    bits_left <= 4'h3;
    burst(2);
    chkb(3'h0, 1, 1'b0);
    @(posedge core_clk);
    bits_left <= 4'h2;
    burst(2);
    chkb(3'h0, 1, 1'b1);
    wr(3'h4, 16'h0000);
    need_char <= 1'b0;
    tx_level <= 6'($urandom_range(1, 63));
    shifting <= 1'b1;
    rd(3'h0);
    chk(got & 16'h0005, 16'h0000);
    $display("test underrun done");
    wr(3'h3, 16'h0008);
    repeat (8) begin
      @(posedge core_clk);
      oldest <= 5'($urandom);
      second <= 5'($urandom);
      rx_level <= 6'($urandom_range(1, 3));
      rx_data <= 16'($urandom);
      @(posedge core_clk);
      n = pops;
      if ($urandom_range(0, 1) == 1) begin
        rd(3'h5);
        chk(got, rx_data);
      end else begin
        dma_rd <= 1'b1;
        @(posedge core_clk);
        dma_rd <= 1'b0;
      end
      w = oldest;
      if (rx_level > 1) w = oldest | second;
      rd(3'h1);
      chk(16'(got[14]), 16'(exc(oldest)));
      if (rx_level > 1) chk(16'(got[15]), 16'(exc(second)));
      chk(16'(got[4:1]), 16'(w[3:0]));
      chk(16'(pops - n), 16'h0001);
    end
    $display("test exceptions done");
    for (int i = 0; i < 6; i++) begin
      wr(3'h4, PM[i % 3]);
      raw <= 5'($urandom);
      hshort <= 1'($urandom);
      cvcmd <= 1'($urandom);
      push <= 1'b1;
      @(posedge core_clk);
      push <= 1'b0;
      #1 chk(16'(pushv), 16'h0001);
      chk(16'(pushed), 16'({sf(PM[i % 3], raw, hshort, cvcmd), raw[3:0]}));
    end
    $display("test queued status done");
    wr(3'h3, 16'h0080);
    for (int i = 0; i < 8; i++) begin
      wr(3'h4, HM[i]);
      n = rx_reqs;
      fire(HB[i]);
      chk(16'(rx_reqs - n), 16'h0001);
      chkb(3'h1, 7, 1'b1);
      wr(3'h1, 16'h0000);
      chkb(3'h1, 7, 1'b1);
      wr(3'h1, 16'h0080);
      chkb(3'h1, 7, 1'b0);
    end
    $display("test hunt done");
    wr(3'h3, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      wr(3'h4, (m == 1) ? 16'h0005 : 16'h0000);
      burst(1);
      @(posedge core_clk);
      rxd <= 1'b1;
      burst((m == 1) ? 14 : 15);
      chkb(3'h1, 6, 1'b0);
      burst(1);
      chkb(3'h1, 6, 1'b1);
      wr(3'h1, 16'h0040);
      chkb(3'h1, 6, 1'b1);
      @(posedge core_clk);
      rxd <= 1'b0;
      repeat (6) @(posedge core_clk);
      chkb(3'h1, 6, 1'b0);
    end
    $display("test idle received done");
    report_and_stop();
  end
endmodule // tb
